// File: include/gtr_cfg.svh
// offsets, field positions, reset values and prescaler counts of the general timer
`ifndef GTR_CFG_SVH
`define GTR_CFG_SVH

// register indices as printed; byte address is four times the index
`define GTR_IDX_COUNT    16'h0100
`define GTR_IDX_PERIOD   16'h0102
`define GTR_IDX_CONTROL  16'h0104
`define GTR_IDX_STATUS   16'h0106
`define GTR_IDX_OSC      16'h0108
`define GTR_ADDR_COUNT   (`GTR_IDX_COUNT << 2)
`define GTR_ADDR_PERIOD  (`GTR_IDX_PERIOD << 2)
`define GTR_ADDR_CONTROL (`GTR_IDX_CONTROL << 2)
`define GTR_ADDR_STATUS  (`GTR_IDX_STATUS << 2)
`define GTR_ADDR_OSC     (`GTR_IDX_OSC << 2)

// timer_control fields
`define GTR_BIT_TIMER_ON     15
`define GTR_BIT_STOP_IDLE    13
`define GTR_BIT_GATE_EN      6
`define GTR_BIT_PS_HI        5
`define GTR_BIT_PS_LO        4
`define GTR_BIT_EXT_SYNC     2
`define GTR_BIT_CLK_SRC      1
`define GTR_CONTROL_MASK     16'ha076

// status and oscillator control fields
`define GTR_BIT_FLAG         0
`define GTR_BIT_IRQ_EN       1
`define GTR_BIT_LPOSC_EN     1

// reset values
`define GTR_RST_COUNT        16'h0000
`define GTR_RST_PERIOD       16'hffff
`define GTR_RST_CONTROL      16'h0000

// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define GTR_PS_TERM_1        8'h00
`define GTR_PS_TERM_8        8'h07
`define GTR_PS_TERM_64       8'h3f
`define GTR_PS_TERM_256      8'hff

`endif

// File: include/gtr_pkg.sv
// types shared by the general timer files
package gtr_pkg;

   typedef enum logic [1:0] {
      GTR_PS_DIV1   = 2'b00,
      GTR_PS_DIV8   = 2'b01,
      GTR_PS_DIV64  = 2'b10,
      GTR_PS_DIV256 = 2'b11
   } gtr_prescale_e;

   typedef enum logic [1:0] {
      GTR_BUS_IDLE    = 2'b00,
      GTR_BUS_RD_WAIT = 2'b01,
      GTR_BUS_RD_DONE = 2'b10
   } gtr_bus_e;

   typedef enum logic [1:0] {
      GTR_SRC_INSTR = 2'b00,
      GTR_SRC_SYNC  = 2'b01,
      GTR_SRC_ASYNC = 2'b10,
      GTR_SRC_LPOSC = 2'b11
   } gtr_source_e;

endpackage

// File: rtl/gtr_prescaler.sv
// input clock prescaler of the general timer
`timescale 1ns/100ps
`include "gtr_cfg.svh"

module gtr_prescaler
   import gtr_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             rst_n_in,
   // control
   input  wire logic             enable_in,
   input  wire logic             clear_in,
   input  wire gtr_prescale_e    select_in,
   // ticks
   input  wire logic             tick_in,
   output logic                  tick_out
);

   logic [WIDTH-1:0] cnt_ff;
   logic [WIDTH-1:0] term;
   logic             at_term;

   always_comb
   begin
      case (select_in)
         GTR_PS_DIV1:   term = WIDTH'(`GTR_PS_TERM_1);
         GTR_PS_DIV8:   term = WIDTH'(`GTR_PS_TERM_8);
         GTR_PS_DIV64:  term = WIDTH'(`GTR_PS_TERM_64);
         GTR_PS_DIV256: term = WIDTH'(`GTR_PS_TERM_256);
         default:       term = WIDTH'(`GTR_PS_TERM_1);
      endcase
   end

   // a ratio lowered below the running count still ends the period at once
   assign at_term  = (cnt_ff >= term);
   assign tick_out = enable_in & tick_in & at_term;

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         cnt_ff <= '0;
      end
      else if (clear_in)
      begin
         cnt_ff <= '0;
      end
      else if (enable_in & tick_in)
      begin
         if (at_term)
         begin
            cnt_ff <= '0;
         end
         else
         begin
            cnt_ff <= cnt_ff + WIDTH'(1);
         end
      end
   end

endmodule

// File: rtl/gtr_timer.sv
// general timer with period match, gated accumulation and low-power clock use
`timescale 1ns/100ps
`include "gtr_cfg.svh"

//Contract
//- Timer mode counts each instruction cycle, wraps to zero after equalling period.
//- Idle with stop-in-idle set halts counting; resumes after idle; else continues.
//- Synchronous counter counts synchronized external rising edges, wraps at period.
//- Asynchronous counter counts every external rising edge unsynchronized, wraps at period.
//- Asynchronous counter halts during idle when stop-in-idle is set.
//- Gate enabled, timer on, internal clock: count only while gate pin high.
//- Prescaler divides input by 1, 8, 64 or 256 per two-bit field.
//- Prescaler clears on count write, timer-on cleared, and device reset.
//- With timer off the prescaler is halted and count writes do not clear it.
//- Control writes leave the count alone; only count writes change it.
//- In sleep only timer on, external clock, sync bit zero keeps counting.
//- Count equal period sets sticky flag, requests interrupt if enabled, software clears.
//- Gated accumulation also sets the flag on gate falling edge.
//- Timer on, external clock, gate off: count low-power oscillator rising edges.
//- Low-power oscillator enable disables normal modes, enables carry-out wake event.
//- Real-time clock counting continues through sleep with unchanged control bits.
module gtr_timer
   import gtr_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int PS_W  = 8
)
(
   // clock and reset
   input  wire logic          core_clk_in,
   input  wire logic          rst_n_in,
   // ahb-lite slave
   input  wire logic          hsel_in,
   input  wire logic [31:0]   haddr_in,
   input  wire logic [1:0]    htrans_in,
   input  wire logic          hwrite_in,
   input  wire logic [2:0]    hsize_in,
   input  wire logic [31:0]   hwdata_in,
   input  wire logic          hready_in,
   output logic               hreadyout_out,
   output logic               hresp_out,
   output logic [31:0]        hrdata_out,
   // processor power state
   input  wire logic          cpu_idle_in,
   input  wire logic          cpu_sleep_in,
   // pins
   input  wire logic          external_clock_gate_pin_in,
   input  wire logic          lowpower_osc_clk_in,
   // events
   output logic               period_match_flag_out,
   output logic               irq_req_out,
   output logic               wake_event_out
);

   // bus state
   gtr_bus_e           bus_state_ff;
   gtr_bus_e           nxt_bus_state;
   logic [31:0]        addr_ff;
   logic               wr_pend_ff;
   logic [31:0]        hrdata_ff;
   logic [31:0]        rd_mux;
   logic               addr_take;

   // registers
   logic [CNT_W-1:0]   timer_count_ff;
   logic [CNT_W-1:0]   period_value_ff;
   logic [15:0]        timer_control_ff;
   logic               period_match_flag_ff;
   logic               period_match_irq_enable_ff;
   logic               lowpower_osc_enable_ff;
   logic               wake_ff;

   // pin sampling
   logic               ext_sync1_ff;
   logic               ext_sync2_ff;
   logic               ext_sync3_ff;
   logic               ext_prev_ff;
   logic               lpo_prev_ff;

   // decoded writes
   logic               wr_count;
   logic               wr_period;
   logic               wr_control;
   logic               wr_status;
   logic               wr_osc;
   logic               ton_clear;

   // control fields
   logic               timer_on;
   logic               stop_in_idle;
   logic               gate_accumulate_enable;
   gtr_prescale_e      prescale_select;
   logic               external_sync_select;
   logic               clock_source_select;

   // counting
   gtr_source_e        src_mode;
   logic               raw_tick;
   logic               run_ok;
   logic               ps_tick;
   logic               ps_clear;
   logic               count_match;
   logic               match_evt;
   logic               gate_fall_evt;
   logic               sync_rise;
   logic               async_rise;
   logic               lpo_rise;

   // ---------------- bus slave ----------------

   assign addr_take = hsel_in & htrans_in[1] & hready_in;

   always_comb
   begin
      nxt_bus_state = bus_state_ff;
      case (bus_state_ff)
         GTR_BUS_IDLE,
         GTR_BUS_RD_DONE:
         begin
            if (addr_take & ~hwrite_in)
            begin
               nxt_bus_state = GTR_BUS_RD_WAIT;
            end
            else
            begin
               nxt_bus_state = GTR_BUS_IDLE;
            end
         end
         GTR_BUS_RD_WAIT:
         begin
            nxt_bus_state = GTR_BUS_RD_DONE;
         end
         default:
         begin
            nxt_bus_state = GTR_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         bus_state_ff <= GTR_BUS_IDLE;
      end
      else
      begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         addr_ff    <= 32'h0000_0000;
         wr_pend_ff <= 1'b0;
      end
      else
      begin
         wr_pend_ff <= addr_take & hwrite_in;
         if (addr_take)
         begin
            addr_ff <= haddr_in;
         end
      end
   end

   // read data is taken one cycle into the data phase, after any write just before it
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (addr_ff)
         {16'h0000, `GTR_ADDR_COUNT}:   rd_mux[CNT_W-1:0] = timer_count_ff;
         {16'h0000, `GTR_ADDR_PERIOD}:  rd_mux[CNT_W-1:0] = period_value_ff;
         {16'h0000, `GTR_ADDR_CONTROL}: rd_mux[15:0] = timer_control_ff & `GTR_CONTROL_MASK;
         {16'h0000, `GTR_ADDR_STATUS}:
         begin
            rd_mux[`GTR_BIT_FLAG]   = period_match_flag_ff;
            rd_mux[`GTR_BIT_IRQ_EN] = period_match_irq_enable_ff;
         end
         {16'h0000, `GTR_ADDR_OSC}:     rd_mux[`GTR_BIT_LPOSC_EN] = lowpower_osc_enable_ff;
         default:                       rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         hrdata_ff <= 32'h0000_0000;
      end
      else if (bus_state_ff == GTR_BUS_RD_WAIT)
      begin
         hrdata_ff <= rd_mux;
      end
   end

   assign hreadyout_out = (bus_state_ff != GTR_BUS_RD_WAIT);
   assign hresp_out     = 1'b0;
   assign hrdata_out    = hrdata_ff;

   assign wr_count   = wr_pend_ff & (addr_ff == {16'h0000, `GTR_ADDR_COUNT});
   assign wr_period  = wr_pend_ff & (addr_ff == {16'h0000, `GTR_ADDR_PERIOD});
   assign wr_control = wr_pend_ff & (addr_ff == {16'h0000, `GTR_ADDR_CONTROL});
   assign wr_status  = wr_pend_ff & (addr_ff == {16'h0000, `GTR_ADDR_STATUS});
   assign wr_osc     = wr_pend_ff & (addr_ff == {16'h0000, `GTR_ADDR_OSC});

   // ---------------- registers ----------------

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         timer_control_ff <= `GTR_RST_CONTROL;
      end
      else if (wr_control)
      begin
         timer_control_ff <= hwdata_in[15:0] & `GTR_CONTROL_MASK;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         period_value_ff <= CNT_W'(`GTR_RST_PERIOD);
      end
      else if (wr_period)
      begin
         period_value_ff <= hwdata_in[CNT_W-1:0];
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         lowpower_osc_enable_ff     <= 1'b0;
         period_match_irq_enable_ff <= 1'b0;
      end
      else
      begin
         if (wr_osc)
         begin
            lowpower_osc_enable_ff <= hwdata_in[`GTR_BIT_LPOSC_EN];
         end
         if (wr_status)
         begin
            period_match_irq_enable_ff <= hwdata_in[`GTR_BIT_IRQ_EN];
         end
      end
   end

   assign timer_on               = timer_control_ff[`GTR_BIT_TIMER_ON];
   assign stop_in_idle           = timer_control_ff[`GTR_BIT_STOP_IDLE];
   assign gate_accumulate_enable = timer_control_ff[`GTR_BIT_GATE_EN];
   assign prescale_select        =
      gtr_prescale_e'(timer_control_ff[`GTR_BIT_PS_HI:`GTR_BIT_PS_LO]);
   assign external_sync_select   = timer_control_ff[`GTR_BIT_EXT_SYNC];
   assign clock_source_select    = timer_control_ff[`GTR_BIT_CLK_SRC];

   // ---------------- pin sampling ----------------

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         ext_sync1_ff <= 1'b0;
         ext_sync2_ff <= 1'b0;
         ext_sync3_ff <= 1'b0;
         ext_prev_ff  <= 1'b0;
         lpo_prev_ff  <= 1'b0;
      end
      else
      begin
         ext_sync1_ff <= external_clock_gate_pin_in;
         ext_sync2_ff <= ext_sync1_ff;
         ext_sync3_ff <= ext_sync2_ff;
         ext_prev_ff  <= external_clock_gate_pin_in;
         lpo_prev_ff  <= lowpower_osc_clk_in;
      end
   end

   assign sync_rise  = ext_sync2_ff & ~ext_sync3_ff;
   assign async_rise = external_clock_gate_pin_in & ~ext_prev_ff;
   assign lpo_rise   = lowpower_osc_clk_in & ~lpo_prev_ff;

   // ---------------- clock source ----------------

   always_comb
   begin
      if (lowpower_osc_enable_ff)
      begin
         src_mode = GTR_SRC_LPOSC;
      end
      else if (!clock_source_select)
      begin
         src_mode = GTR_SRC_INSTR;
      end
      else if (external_sync_select)
      begin
         src_mode = GTR_SRC_SYNC;
      end
      else
      begin
         src_mode = GTR_SRC_ASYNC;
      end
   end

   always_comb
   begin
      case (src_mode)
         // gated accumulation passes instruction cycles only while the pin is high
         GTR_SRC_INSTR: raw_tick = ~gate_accumulate_enable | external_clock_gate_pin_in;
         GTR_SRC_SYNC:  raw_tick = sync_rise;
         GTR_SRC_ASYNC: raw_tick = async_rise;
         // normal modes are off; only the real-time clock setup counts
         GTR_SRC_LPOSC: raw_tick = clock_source_select & ~gate_accumulate_enable & lpo_rise;
         default:       raw_tick = 1'b0;
      endcase
   end

   // idle halts all sources when asked; sleep stops every source unless the external clock is selected with the sync bit clear (async external, low-power oscillator)
   assign run_ok = ~(cpu_idle_in & stop_in_idle)
                 & (~cpu_sleep_in | (clock_source_select & ~external_sync_select));

   // clears only act while the prescaler clock runs, or on the edge that stops it
   assign ton_clear = wr_control & timer_on & ~hwdata_in[`GTR_BIT_TIMER_ON];
   assign ps_clear  = timer_on & (wr_count | ton_clear);

   gtr_prescaler #(
      .WIDTH       (PS_W)
   ) u_prescaler (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .enable_in   (timer_on),
      .clear_in    (ps_clear),
      .select_in   (prescale_select),
      .tick_in     (raw_tick & run_ok),
      .tick_out    (ps_tick)
   );

   // ---------------- counter ----------------

   assign count_match = (timer_count_ff == period_value_ff);
   assign match_evt   = ps_tick & count_match & ~wr_count;

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         timer_count_ff <= CNT_W'(`GTR_RST_COUNT);
      end
      else if (wr_count)
      begin
         timer_count_ff <= hwdata_in[CNT_W-1:0];
      end
      else if (ps_tick)
      begin
         if (count_match)
         begin
            timer_count_ff <= '0;
         end
         else
         begin
            timer_count_ff <= timer_count_ff + CNT_W'(1);
         end
      end
   end

   // ---------------- events ----------------

   assign gate_fall_evt = timer_on & (src_mode == GTR_SRC_INSTR) & gate_accumulate_enable
                        & ext_prev_ff & ~external_clock_gate_pin_in;

   // a new event wins over a software clear in the same cycle
   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         period_match_flag_ff <= 1'b0;
      end
      else if (match_evt | gate_fall_evt)
      begin
         period_match_flag_ff <= 1'b1;
      end
      else if (wr_status & hwdata_in[`GTR_BIT_FLAG])
      begin
         period_match_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (!rst_n_in)
      begin
         wake_ff <= 1'b0;
      end
      else
      begin
         wake_ff <= match_evt & lowpower_osc_enable_ff;
      end
   end

   assign period_match_flag_out = period_match_flag_ff;
   assign irq_req_out           = period_match_flag_ff & period_match_irq_enable_ff;
   assign wake_event_out        = wake_ff;

endmodule

// File: testbench/gtr_pin_model.sv
// far side: external clock or gate pin and low-power oscillator source
`timescale 1ns/100ps
module gtr_pin_model
(
   // clock
   input  wire logic        core_clk_in,
   // command
   input  wire logic        start_in,
   input  wire logic [15:0] pin_edges_in,
   input  wire logic [15:0] osc_edges_in,
   input  wire logic [7:0]  half_in,
   // pins
   output logic             pin_out,
   output logic             osc_out,
   output logic             busy_out
);
   logic [15:0] pin_left = 16'h0;
   logic [15:0] osc_left = 16'h0;
   logic [7:0]  phase = 8'h0;
   logic        pin_ff = 1'b0;
   logic        osc_ff = 1'b0;
   assign pin_out = pin_ff;
   assign osc_out = osc_ff;
   assign busy_out = (pin_left != 16'h0) || (osc_left != 16'h0) || pin_ff || osc_ff;
   // both sources stand low once the requested rising edges are out
   always @(posedge core_clk_in)
   begin
      if (start_in)
      begin
         pin_left <= pin_edges_in;
         osc_left <= osc_edges_in;
         phase <= 8'h0;
      end
      else if (phase + 8'h1 >= half_in)
      begin
         phase <= 8'h0;
         pin_ff <= !pin_ff && (pin_left != 16'h0);
         osc_ff <= !osc_ff && (osc_left != 16'h0);
         if (pin_ff)
            pin_left <= pin_left - 16'h1;
         if (osc_ff)
            osc_left <= osc_left - 16'h1;
      end
      else
         phase <= phase + 8'h1;
   end
endmodule

// File: testbench/gtr_timer_chk.sv
// bus timing and event output checker for the general timer
`timescale 1ns/100ps
module gtr_timer_chk
   import gtr_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   // bus
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   input  wire logic        hreadyout_out,
   input  wire logic [31:0] hrdata_out,
   // events
   input  wire logic        period_match_flag_out,
   input  wire logic        irq_req_out,
   input  wire logic        wake_event_out
);
   logic take_rd;
   logic take_wr;
   logic unmapped;
   logic clr_ph_ff;
   assign take_rd = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
   assign take_wr = hsel_in & htrans_in[1] & hready_in & hwrite_in;
   assign unmapped = !(haddr_in inside {32'h400, 32'h408, 32'h410, 32'h418, 32'h420});
   // status write data phase, when a flag clear may land
   always_ff @(posedge core_clk_in)
   begin
      clr_ph_ff <= rst_n_in & take_wr & (haddr_in == 32'h418);
   end
   default clocking dc @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   rd_wait_a: assert property (take_rd |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state wrong");
   wr_nowait_a: assert property (take_wr |=> hreadyout_out)
      else $error("write stalled");
   rdy_low_cause_a: assert property (!hreadyout_out |-> $past(take_rd))
      else $error("stall without read");
   unmapped_zero_a: assert property (take_rd && unmapped |=> ##1 hrdata_out == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (take_rd |=> ##1 hrdata_out[31:16] == 16'h0)
      else $error("upper read bits set");
   irq_needs_flag_a: assert property (irq_req_out |-> period_match_flag_out)
      else $error("request without flag");
   flag_clear_a: assert property ($fell(period_match_flag_out) |->
      $past(clr_ph_ff && hwdata_in[0]))
      else $error("flag fell without clear");
   wake_pulse_a: assert property (wake_event_out |=> !wake_event_out)
      else $error("wake longer than one cycle");
   rst_values_a: assert property ($rose(rst_n_in) |->
      !period_match_flag_out && !wake_event_out && hreadyout_out)
      else $error("outputs not at reset values");
endmodule

bind gtr_timer gtr_timer_chk gtr_timer_chk_i (.core_clk_in, .rst_n_in, .hsel_in, .haddr_in,
   .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out, .hrdata_out,
   .period_match_flag_out, .irq_req_out, .wake_event_out);

// File: testbench/testbench.sv
// self-checking bench for the general timer
`timescale 1ns/100ps
module testbench;
   import gtr_pkg::*;
   logic        core_clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        hsel_in = 1'b0;
   logic [31:0] haddr_in = 32'h0;
   logic [1:0]  htrans_in = 2'b00;
   logic        hwrite_in = 1'b0;
   logic [31:0] hwdata_in = 32'h0;
   logic        cpu_idle_in = 1'b0;
   logic        cpu_sleep_in = 1'b0;
   logic        start = 1'b0;
   logic [15:0] pin_n = 16'h0;
   logic [15:0] osc_n = 16'h0;
   logic [7:0]  half = 8'h3;
   logic [31:0] exp_q[$];
   logic        rd_dp = 1'b0;
   logic        pin, osc, busy, rdy, resp, flag, irq, wake;
   logic [31:0] rdata;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          wake_cnt = 0;
   logic [15:0] ctl_tab[6] = '{16'h8006, 16'h8012, 16'h8026, 16'h8032, 16'h8006, 16'ha002};
   logic [1:0]  pwr_tab[6] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b10, 2'b01};

   gtr_timer gtr_timer_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
      .hwdata_in(hwdata_in), .hready_in(rdy), .hreadyout_out(rdy), .hresp_out(resp),
      .hrdata_out(rdata), .cpu_idle_in(cpu_idle_in), .cpu_sleep_in(cpu_sleep_in),
      .external_clock_gate_pin_in(pin), .lowpower_osc_clk_in(osc),
      .period_match_flag_out(flag), .irq_req_out(irq), .wake_event_out(wake));
   gtr_pin_model gtr_pin_model_i (.core_clk_in(core_clk_in), .start_in(start),
      .pin_edges_in(pin_n), .osc_edges_in(osc_n), .half_in(half), .pin_out(pin),
      .osc_out(osc), .busy_out(busy));

   always #12.5 core_clk_in = ~core_clk_in;

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
      cmp_count++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // one single transfer; a read notes its expected data
   task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
      hsel_in <= 1'b1;
      htrans_in <= 2'b10;
      haddr_in <= a;
      hwrite_in <= wr;
      do @(posedge core_clk_in); while (rdy !== 1'b1);
      hsel_in <= 1'b0;
      htrans_in <= 2'b00;
      hwdata_in <= d;
      if (!wr)
         exp_q.push_back(d);
      do @(posedge core_clk_in); while (rdy !== 1'b1);
   endtask

   task automatic run(input int np, input int no, input int h);
      pin_n <= np[15:0];
      osc_n <= no[15:0];
      half <= h[7:0];
      start <= 1'b1;
      @(posedge core_clk_in);
      start <= 1'b0;
      @(posedge core_clk_in);
      while (busy) @(posedge core_clk_in);
      repeat (4) @(posedge core_clk_in);
   endtask

   task automatic pin_chk(input string nm, input logic ex);
      @(negedge core_clk_in);
      check(nm, {31'h0, ex}, {31'h0, irq});
      check("flag", {31'h0, ex}, {31'h0, flag});
      @(posedge core_clk_in);
   endtask

   // takes read results off the queue as they appear
   always @(posedge core_clk_in)
   begin
      if (rd_dp && rdy === 1'b1)
      begin
         rd_dp = 1'b0;
         check("hrdata", exp_q.pop_front(), rdata);
         check("hresp", 32'h0, {31'h0, resp});
      end
      if (hsel_in && htrans_in[1] && rdy && !hwrite_in)
         rd_dp = 1'b1;
      if (wake === 1'b1)
         wake_cnt++;
      cyc++;
      if (cyc > 40000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   initial
   begin
      int n;
      int p;
      int e;
      int dv;
      logic stp;
      void'($urandom(32'h2b758b58));
      repeat (6) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      @(posedge core_clk_in);
      bus(32'h400, 0, 32'h0);
      bus(32'h408, 0, 32'hffff);
      bus(32'h410, 0, 32'h0);
      bus(32'h404, 0, 32'h0);
      bus(32'h410, 1, 32'hffff);
      bus(32'h410, 0, 32'ha076);
      bus(32'h400, 0, 32'h0);
      // gated accumulation, then idle with and without stop-in-idle
      n = $urandom_range(40, 3);
      bus(32'h410, 1, 32'h8040);
      bus(32'h400, 1, 32'h0);
      run(1, 0, n);
      bus(32'h400, 0, n);
      bus(32'h418, 0, 32'h1);
      bus(32'h410, 1, 32'ha040);
      cpu_idle_in <= 1'b1;
      run(1, 0, 5);
      bus(32'h400, 0, n);
      bus(32'h410, 1, 32'h8040);
      run(1, 0, 6);
      bus(32'h400, 0, n + 6);
      cpu_idle_in <= 1'b0;
      bus(32'h418, 1, 32'h2);
      pin_chk("irq", 1'b1);
      bus(32'h418, 1, 32'h3);
      bus(32'h418, 0, 32'h2);
      pin_chk("irq", 1'b0);
      // external counting in every prescale, sync and power state
      for (int i = 0; i < 6; i++)
      begin
         dv = (ctl_tab[i][5:4] == 2'b11) ? 256 : 1 << (3 * ctl_tab[i][5:4]);
         e = $urandom_range(4, 1) * dv + $urandom_range(dv - 1, 0);
         stp = (pwr_tab[i][0] && ctl_tab[i][13]) || (pwr_tab[i][1] && ctl_tab[i][2]);
         bus(32'h410, 1, {16'h0, ctl_tab[i]});
         bus(32'h400, 1, 32'h0);
         {cpu_sleep_in, cpu_idle_in} <= pwr_tab[i];
         run(e, 0, 3);
         {cpu_sleep_in, cpu_idle_in} <= 2'b00;
         bus(32'h400, 0, stp ? 0 : e / dv);
      end
      // clearing timer_on drops a partial prescale count
      bus(32'h410, 1, 32'h8012);
      bus(32'h400, 1, 32'h0);
      run(5, 0, 3);
      bus(32'h410, 1, 32'h0012);
      bus(32'h410, 1, 32'h8012);
      run(3, 0, 3);
      bus(32'h400, 0, 32'h0);
      // period wrap
      p = $urandom_range(9, 2);
      bus(32'h408, 1, p);
      bus(32'h410, 1, 32'h8002);
      bus(32'h400, 1, 32'h0);
      bus(32'h418, 1, 32'h1);
      run(p + 1, 0, 3);
      bus(32'h400, 0, 32'h0);
      bus(32'h418, 0, 32'h1);
      run(2, 0, 3);
      bus(32'h400, 0, 32'h2);
      // low-power oscillator counting through sleep; pin edges ignored
      bus(32'h420, 1, 32'h2);
      bus(32'h418, 1, 32'h1);
      bus(32'h400, 1, 32'h0);
      cpu_sleep_in <= 1'b1;
      run(5, p + 1, 4);
      cpu_sleep_in <= 1'b0;
      bus(32'h400, 0, 32'h0);
      bus(32'h418, 0, 32'h1);
      check("wake", 32'h1, wake_cnt);
      repeat (3) @(posedge core_clk_in);
      end_sim();
   end
endmodule
